/* File: aapt_ctrl.sv */
// Automatic acknowledgement packet transaction controller, top level
module aapt_ctrl
	import aapt_pkg::*;
#(
	parameter int RETRY_STEP_CYC = AAPT_RETRY_STEP_CYC
) (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   clk_en,
	input  wire logic                   radio_activate,
	input  wire logic                   spi_select_n,
	input  wire logic                   tx_byte_strobe,
	input  wire logic                   primary_receive_select,
	input  wire logic                   pipe0_auto_ack_enable,
	input  wire logic [AAPT_NUM_PIPES-1:0] auto_ack_enable_mask,
	input  wire logic [AAPT_NUM_PIPES-1:0] pipe_enable_mask,
	input  wire logic [3:0]             retry_limit,
	input  wire logic [3:0]             retry_delay,
	input  wire logic                   air_rate_2m,
	input  wire logic                   tx_skip_ack,
	input  wire logic                   status_write,
	input  wire logic [AAPT_FLAG_W-1:0] status_write_data,
	input  wire logic                   rx_fifo_read,
	input  wire logic                   radio_tx_done,
	input  wire logic                   radio_ack_received,
	input  wire logic                   radio_packet_active,
	input  wire logic                   rx_packet_valid,
	input  wire logic                   rx_addr_match,
	input  wire logic                   rx_crc_ok,
	input  wire logic [2:0]             rx_pipe,
	input  wire logic                   rx_skip_ack,
	output logic                        radio_power_up,
	output logic                        radio_rx_on,
	output logic                        radio_tx_start,
	output logic                        radio_rate_2m,
	output logic                        ack_with_payload,
	output logic [AAPT_LEN_W-1:0]       tx_payload_length,
	output logic                        irq_n,
	output logic                        transmit_done_flag,
	output logic                        retry_exhausted_flag,
	output logic                        receive_ready_flag,
	output logic [2:0]                  receive_pipe_number,
	output logic [3:0]                  retry_count,
	output logic [3:0]                  lost_packet_count,
	output logic [1:0]                  rx_fifo_count
);
	aapt_txq_if txq ();
	aapt_txq u_txq (
		.clock  (clock),
		.rst    (rst),
		.clk_en (clk_en),
		.q      (txq.queue)
	);
	// Pins are asynchronous to the clock
	logic act_m, act_s, act_d, sel_m, sel_s, sel_d;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			act_m <= 1'b0;
			act_s <= 1'b0;
			act_d <= 1'b0;
			sel_m <= 1'b1;
			sel_s <= 1'b1;
			sel_d <= 1'b1;
		end else if (clk_en) begin
			act_m <= radio_activate;
			act_s <= act_m;
			act_d <= act_s;
			sel_m <= spi_select_n;
			sel_s <= sel_m;
			sel_d <= sel_s;
		end
	end
	aapt_state_t            state, next_state;
	logic [AAPT_TMR_W-1:0]  timer, next_timer;
	logic [3:0]             next_retry, next_lost;
	logic [AAPT_FLAG_W-1:0] flags, next_flags, set_flags, clr_flags;
	logic [1:0]             next_rx_cnt;
	logic [2:0]             next_pipe;
	logic                   next_tx_start, next_ackpay, next_pwr, next_rx_on, next_irq_n;
	logic [AAPT_LEN_W-1:0]  next_txlen, byte_cnt, next_byte_cnt;
	logic                   skip_ack, next_skip_ack;
	logic                   act_rise, finish_ok, finish_fail, start_new, start_retry;
	logic                   rx_good, rx_push, more_tx, exh_after;
	logic [AAPT_TMR_W-1:0]  ard_cyc;
	assign act_rise = act_s && !act_d;
	assign ard_cyc  = AAPT_TMR_W'(RETRY_STEP_CYC * (int'(retry_delay) + 1));
	assign rx_good  = rx_packet_valid && rx_addr_match && rx_crc_ok
		&& (rx_pipe < 3'(AAPT_NUM_PIPES)) && pipe_enable_mask[rx_pipe];
	always_comb begin
		next_state    = state;
		next_timer    = (timer == '1) ? timer : timer + 1'b1;
		next_retry    = retry_count;
		next_lost     = lost_packet_count;
		next_pipe     = receive_pipe_number;
		next_txlen    = tx_payload_length;
		next_ackpay   = ack_with_payload;
		next_skip_ack = skip_ack;
		next_tx_start = 1'b0;
		set_flags     = '0;
		finish_ok     = 1'b0;
		finish_fail   = 1'b0;
		start_new     = 1'b0;
		start_retry   = 1'b0;
		rx_push       = 1'b0;
		txq.pop       = 1'b0;
		case (state)
			ST_STBY1: begin
				if (!primary_receive_select) begin
					start_new = act_rise && (txq.count != '0) && !flags[AAPT_FLAG_EXH];
				end else if (act_s) begin
					next_state = ST_SETTLE;
					next_timer = '0;
				end
			end
			ST_STBY2: begin
				if (!act_s) begin
					next_state = ST_STBY1;
				end else if (!primary_receive_select) begin
					start_new = (txq.count != '0) && !flags[AAPT_FLAG_EXH];
				end
			end
			ST_TX: begin
				if (radio_tx_done) begin
					if (pipe0_auto_ack_enable && !skip_ack) begin
						next_state = ST_ACKWAIT;
						next_timer = '0;
					end else begin
						finish_ok = 1'b1;
					end
				end
			end
			ST_ACKWAIT: begin
				if (radio_ack_received) begin
					finish_ok = 1'b1;
				end else if (timer >= AAPT_TMR_W'(AAPT_ACK_WIN_CYC - 1) && !radio_packet_active) begin
					next_state = ST_RETRYWAIT;
				end
			end
			ST_RETRYWAIT: begin
				if (timer >= ard_cyc - 1'b1) begin
					if (retry_count < retry_limit) begin
						start_retry = 1'b1;
						next_retry  = retry_count + 1'b1;
					end else begin
						finish_fail = 1'b1;
					end
				end
			end
			ST_SETTLE: begin
				if (!act_s) begin
					next_state = ST_STBY1;
				end else if (timer >= AAPT_TMR_W'(AAPT_SETTLE_CYC - 1)) begin
					next_state = ST_RX;
				end
			end
			ST_RX: begin
				if (!act_s) begin
					next_state = ST_STBY1;
				end else if (rx_good && (rx_fifo_count != 2'(AAPT_RXQ_DEPTH) || rx_fifo_read)) begin
					rx_push   = 1'b1;
					next_pipe = rx_pipe;
					set_flags[AAPT_FLAG_RXREADY] = 1'b1;
					if (auto_ack_enable_mask[rx_pipe] && !rx_skip_ack) begin
						next_state    = ST_RXACK;
						next_tx_start = 1'b1;
						next_ackpay   = (txq.count != '0);
						next_txlen    = (txq.count != '0) ? txq.head_len : '0;
					end
				end
			end
			ST_RXACK: begin
				if (radio_tx_done) begin
					txq.pop    = ack_with_payload;
					next_state = act_s ? ST_RX : ST_STBY1;
				end
			end
			default: begin
				next_state = ST_STBY1;
			end
		endcase
		if (finish_ok) begin
			set_flags[AAPT_FLAG_TXDONE] = 1'b1;
			txq.pop = 1'b1;
		end
		if (finish_fail) begin
			set_flags[AAPT_FLAG_EXH] = 1'b1;
			if (lost_packet_count != AAPT_CNT_MAX) begin
				next_lost = lost_packet_count + 1'b1;
			end
		end
		more_tx   = finish_ok ? (txq.count > AAPT_TXQ_CW'(1)) : (txq.count != '0);
		exh_after = finish_fail || flags[AAPT_FLAG_EXH];
		if (finish_ok || finish_fail) begin
			if (!act_s) begin
				next_state = ST_STBY1;
			end else if (more_tx && !exh_after && !primary_receive_select) begin
				start_new = 1'b1;
			end else begin
				next_state = ST_STBY2;
			end
		end
		if (start_new || start_retry) begin
			next_state    = ST_TX;
			next_tx_start = 1'b1;
			next_txlen    = txq.head_len;
			next_ackpay   = 1'b0;
		end
		if (start_new) begin
			next_retry    = '0;
			next_skip_ack = tx_skip_ack;
		end
		// A set in the same cycle as its clear wins
		clr_flags  = status_write ? status_write_data : '0;
		next_flags = (flags & ~clr_flags) | set_flags;
		next_irq_n = ~|next_flags;
		next_rx_cnt = rx_fifo_count;
		if (rx_push && !(rx_fifo_read && rx_fifo_count != '0)) begin
			next_rx_cnt = rx_fifo_count + 1'b1;
		end else if (!rx_push && rx_fifo_read && rx_fifo_count != '0) begin
			next_rx_cnt = rx_fifo_count - 1'b1;
		end
		next_pwr   = (next_state != ST_STBY1) && (next_state != ST_STBY2)
			&& (next_state != ST_RETRYWAIT);
		next_rx_on = (next_state == ST_RX) || (next_state == ST_ACKWAIT);
		// Bytes counted only while selected; release of select closes the packet
		next_byte_cnt = byte_cnt;
		txq.push      = 1'b0;
		txq.push_len  = byte_cnt;
		if (!sel_s && tx_byte_strobe && byte_cnt != AAPT_LEN_W'(AAPT_MAX_PAYLOAD)) begin
			next_byte_cnt = byte_cnt + 1'b1;
		end
		if (sel_s && !sel_d) begin
			txq.push      = (byte_cnt != '0);
			next_byte_cnt = '0;
		end
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state                <= ST_STBY1;
			timer                <= '0;
			retry_count          <= '0;
			lost_packet_count    <= '0;
			flags                <= '0;
			rx_fifo_count        <= '0;
			receive_pipe_number  <= '0;
			radio_tx_start       <= 1'b0;
			tx_payload_length    <= '0;
			ack_with_payload     <= 1'b0;
			skip_ack             <= 1'b0;
			radio_power_up       <= 1'b0;
			radio_rx_on          <= 1'b0;
			radio_rate_2m        <= 1'b0;
			irq_n                <= 1'b1;
			byte_cnt             <= '0;
		end else if (clk_en) begin
			state                <= next_state;
			timer                <= next_timer;
			retry_count          <= next_retry;
			lost_packet_count    <= next_lost;
			flags                <= next_flags;
			rx_fifo_count        <= next_rx_cnt;
			receive_pipe_number  <= next_pipe;
			radio_tx_start       <= next_tx_start;
			tx_payload_length    <= next_txlen;
			ack_with_payload     <= next_ackpay;
			skip_ack             <= next_skip_ack;
			radio_power_up       <= next_pwr;
			radio_rx_on          <= next_rx_on;
			radio_rate_2m        <= air_rate_2m;
			irq_n                <= next_irq_n;
			byte_cnt             <= next_byte_cnt;
		end
	end
	assign transmit_done_flag   = flags[AAPT_FLAG_TXDONE];
	assign retry_exhausted_flag = flags[AAPT_FLAG_EXH];
	assign receive_ready_flag   = flags[AAPT_FLAG_RXREADY];
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst || !clk_en);
	sequence s_enter_tx; (state != ST_TX) ##1 (state == ST_TX); endsequence
	sequence s_ack_to_idle; (state == ST_ACKWAIT) ##1 (state == ST_RETRYWAIT); endsequence
	sequence s_settle_done; (state == ST_SETTLE) ##1 (state == ST_RX); endsequence
	AST_TX_START: assert property ((state == ST_STBY1) && !primary_receive_select && act_rise
		&& (txq.count != '0) && !retry_exhausted_flag |=> (state == ST_TX) && radio_tx_start)
		else $error("transmit did not start on activate pulse");
	// Start is decided one cycle before the state shows it
	AST_EXH_BLOCKS: assert property (s_enter_tx |-> !$past(retry_exhausted_flag)
		|| $past(state) == ST_RETRYWAIT) else $error("transmit started while retries exhausted");
	AST_ACK_DONE: assert property ((state == ST_ACKWAIT) && radio_ack_received
		|=> transmit_done_flag && !irq_n) else $error("ack did not set done flag");
	AST_LOST_CNT: assert property ($rose(retry_exhausted_flag) && $past(state) == ST_RETRYWAIT
		|-> lost_packet_count == $past(lost_packet_count) + 4'h1
		|| lost_packet_count == AAPT_CNT_MAX) else $error("lost packet count not advanced");
	AST_IRQ_ACTIVE: assert property (transmit_done_flag || retry_exhausted_flag
		|| receive_ready_flag |-> !irq_n) else $error("interrupt inactive with a flag set");
	AST_IRQ_RELEASE: assert property (!transmit_done_flag && !retry_exhausted_flag
		&& !receive_ready_flag |-> irq_n) else $error("interrupt active with no flag set");
	AST_SETTLE_TIME: assert property (s_settle_done |->
		$past(timer) >= AAPT_TMR_W'(AAPT_SETTLE_CYC - 1))
		else $error("receiver listened before settle time");
	AST_STBY2_EXIT: assert property ((state == ST_STBY2) && !act_s |=> state == ST_STBY1)
		else $error("standby-II did not drop to standby-I");
	AST_ACK_WINDOW: assert property (s_ack_to_idle |->
		$past(timer) >= AAPT_TMR_W'(AAPT_ACK_WIN_CYC - 1) && !$past(radio_packet_active))
		else $error("ack wait left early");
	AST_NO_RETRY_ZERO: assert property ((retry_limit == 4'h0) && (state == ST_RETRYWAIT)
		|=> state != ST_TX) else $error("retransmit with zero retry limit");
	AST_BAD_CRC: assert property ((state == ST_RX) && rx_packet_valid && !rx_crc_ok
		&& !receive_ready_flag |=> !receive_ready_flag)
		else $error("packet with bad crc accepted");
	AST_W1C: assert property (status_write && status_write_data[AAPT_FLAG_TXDONE]
		&& !finish_ok |=> !transmit_done_flag) else $error("write one did not clear done flag");
endmodule : aapt_ctrl

/* File: aapt_pkg.sv */
// Constants, flag layout and state codes of the packet transaction controller
package aapt_pkg;
	localparam int AAPT_CLK_MHZ        = 10;
	localparam int AAPT_SETTLE_US      = 130;
	localparam int AAPT_SETTLE_CYC     = AAPT_SETTLE_US * AAPT_CLK_MHZ;
	localparam int AAPT_ACK_WIN_US     = 250;
	localparam int AAPT_ACK_WIN_CYC    = AAPT_ACK_WIN_US * AAPT_CLK_MHZ;
	localparam int AAPT_RETRY_STEP_US  = 250;
	localparam int AAPT_RETRY_STEP_CYC = AAPT_RETRY_STEP_US * AAPT_CLK_MHZ;
	localparam int AAPT_TMR_W          = 16;
	localparam int AAPT_LEN_W          = 6;
	localparam int AAPT_MAX_PAYLOAD    = 32;
	localparam int AAPT_TXQ_DEPTH      = 4;
	localparam int AAPT_TXQ_AW         = 2;
	localparam int AAPT_TXQ_CW         = 3;
	localparam int AAPT_RXQ_DEPTH      = 3;
	localparam int AAPT_NUM_PIPES      = 6;
	localparam int AAPT_FLAG_W         = 3;
	localparam int AAPT_FLAG_EXH       = 0;
	localparam int AAPT_FLAG_TXDONE    = 1;
	localparam int AAPT_FLAG_RXREADY   = 2;
	localparam logic [3:0] AAPT_CNT_MAX = 4'hf;

	typedef enum logic [7:0] {
		ST_STBY1     = 8'h01,
		ST_STBY2     = 8'h02,
		ST_TX        = 8'h04,
		ST_ACKWAIT   = 8'h08,
		ST_RETRYWAIT = 8'h10,
		ST_SETTLE    = 8'h20,
		ST_RX        = 8'h40,
		ST_RXACK     = 8'h80
	} aapt_state_t;
endpackage : aapt_pkg

/* File: aapt_txq_if.sv */
// Link between the controller and its queue of transmit payload lengths
interface aapt_txq_if;
	import aapt_pkg::*;
	logic                   push;
	logic [AAPT_LEN_W-1:0]  push_len;
	logic                   pop;
	logic [AAPT_LEN_W-1:0]  head_len;
	logic [AAPT_TXQ_CW-1:0] count;
	logic                   full;
	modport ctrl  (output push, push_len, pop, input head_len, count, full);
	modport queue (input push, push_len, pop, output head_len, count, full);
endinterface : aapt_txq_if

/* File: aapt_txq.sv */
// Queue of payload lengths waiting in the transmit FIFO
module aapt_txq
	import aapt_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic clk_en,
	aapt_txq_if.queue q
);
	logic [AAPT_LEN_W-1:0]  mem      [AAPT_TXQ_DEPTH];
	logic [AAPT_LEN_W-1:0]  next_mem [AAPT_TXQ_DEPTH];
	logic [AAPT_TXQ_AW-1:0] wr_ptr, next_wr_ptr;
	logic [AAPT_TXQ_AW-1:0] rd_ptr, next_rd_ptr;
	logic [AAPT_TXQ_CW-1:0] count, next_count;
	logic                   do_push, do_pop;

	always_comb begin
		do_push     = q.push && (count != AAPT_TXQ_CW'(AAPT_TXQ_DEPTH));
		do_pop      = q.pop && (count != '0);
		next_mem    = mem;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (do_push) begin
			next_mem[wr_ptr] = q.push_len;
			next_wr_ptr      = wr_ptr + 1'b1;
		end
		if (do_pop) begin
			next_rd_ptr = rd_ptr + 1'b1;
		end
		if (do_push && !do_pop) begin
			next_count = count + 1'b1;
		end else if (do_pop && !do_push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < AAPT_TXQ_DEPTH; i++) begin
				mem[i] <= '0;
			end
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (clk_en) begin
			mem    <= next_mem;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	assign q.head_len = mem[rd_ptr];
	assign q.count    = count;
	assign q.full     = (count == AAPT_TXQ_CW'(AAPT_TXQ_DEPTH));
endmodule : aapt_txq

/* File: aapt_radio_model.sv */
// Radio front end model: answers send requests, returns acks on demand
module aapt_radio_model (
	input  wire logic clock,
	input  wire logic radio_tx_start,
	input  wire logic radio_rx_on,
	input  wire logic ack_enable,
	input  wire logic slow,
	output logic      radio_tx_done,
	output logic      radio_ack_received
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		radio_tx_done = 1'b0;
		radio_ack_received = 1'b0;
		forever begin
			@(negedge clock);
			if (radio_tx_start === 1'b1) begin
				// Air time is arbitrary, far below the ack window
				repeat (20) @(negedge clock);
				radio_tx_done = 1'b1;
				@(negedge clock);
				radio_tx_done = 1'b0;
				// Acks reach pipe 0 only with its address set to the target
				if (ack_enable) begin
					repeat (slow ? 200 : 30) @(negedge clock);
					// An ack only exists while the device listens
					radio_ack_received = radio_rx_on;
					@(negedge clock);
					radio_ack_received = 1'b0;
				end
			end
		end
	end
endmodule : aapt_radio_model

/* File: tb.sv */
// Self-checking bench of the packet transaction controller
module tb;
	import aapt_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst = 1, clk_en = 1, radio_activate = 0, spi_select_n = 1, spi_sck = 0;
	logic tx_byte_strobe = 0, primary_receive_select = 0, pipe0_auto_ack_enable = 1;
	logic [5:0] auto_ack_enable_mask = 6'h00, pipe_enable_mask = 6'h00;
	logic [3:0] retry_limit = 4'h2, retry_delay = 4'h0;
	logic air_rate_2m = 1, tx_skip_ack = 0, status_write = 0, rx_fifo_read = 0;
	logic [2:0] status_write_data = 3'h0, rx_pipe = 3'h0;
	logic radio_tx_done, radio_ack_received, radio_packet_active = 0, ack_enable = 1, slow = 0;
	logic rx_packet_valid = 0, rx_addr_match = 0, rx_crc_ok = 0, rx_skip_ack = 0;
	logic radio_power_up, radio_rx_on, radio_tx_start, radio_rate_2m, ack_with_payload, irq_n;
	logic transmit_done_flag, retry_exhausted_flag, receive_ready_flag, last_awp;
	logic [5:0] tx_payload_length, last_len;
	logic [2:0] receive_pipe_number;
	logic [3:0] retry_count, lost_packet_count;
	logic [1:0] rx_fifo_count;
	int fails = 0, total_checks = 0, starts = 0, cycles = 0, s;
	aapt_ctrl #(.RETRY_STEP_CYC(30)) dut (.clock(clock), .rst(rst), .clk_en(clk_en),
		.radio_activate(radio_activate), .spi_select_n(spi_select_n),
		.tx_byte_strobe(tx_byte_strobe), .primary_receive_select(primary_receive_select),
		.pipe0_auto_ack_enable(pipe0_auto_ack_enable),
		.auto_ack_enable_mask(auto_ack_enable_mask), .pipe_enable_mask(pipe_enable_mask),
		.retry_limit(retry_limit), .retry_delay(retry_delay), .air_rate_2m(air_rate_2m),
		.tx_skip_ack(tx_skip_ack), .status_write(status_write),
		.status_write_data(status_write_data), .rx_fifo_read(rx_fifo_read),
		.radio_tx_done(radio_tx_done), .radio_ack_received(radio_ack_received),
		.radio_packet_active(radio_packet_active), .rx_packet_valid(rx_packet_valid),
		.rx_addr_match(rx_addr_match), .rx_crc_ok(rx_crc_ok), .rx_pipe(rx_pipe),
		.rx_skip_ack(rx_skip_ack), .radio_power_up(radio_power_up),
		.radio_rx_on(radio_rx_on), .radio_tx_start(radio_tx_start),
		.radio_rate_2m(radio_rate_2m), .ack_with_payload(ack_with_payload),
		.tx_payload_length(tx_payload_length), .irq_n(irq_n),
		.transmit_done_flag(transmit_done_flag), .retry_exhausted_flag(retry_exhausted_flag),
		.receive_ready_flag(receive_ready_flag), .receive_pipe_number(receive_pipe_number),
		.retry_count(retry_count), .lost_packet_count(lost_packet_count),
		.rx_fifo_count(rx_fifo_count));
	aapt_radio_model radio (.clock(clock), .radio_tx_start(radio_tx_start),
		.radio_rx_on(radio_rx_on), .ack_enable(ack_enable), .slow(slow),
		.radio_tx_done(radio_tx_done), .radio_ack_received(radio_ack_received));
	initial begin
		forever #50 clock = ~clock;
	end
	// Sampled after the edge so a one-cycle start pulse is settled
	always @(posedge clock) begin
		#1;
		if (radio_tx_start === 1'b1) begin
			starts++;
			last_len = tx_payload_length;
			last_awp = ack_with_payload;
		end
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			results();
		end
	end
	task results;
		if (fails == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	task chk_bit(input logic got, input logic exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %b", $time, msg, got);
		end
	endtask : chk_bit
	task chk_val(input logic [5:0] got, input logic [5:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %0d want %0d", $time, msg, got, exp);
		end
	endtask : chk_val
	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	// One select-low burst; byte pace follows an 800 ns serial clock
	task load(input int n);
		spi_select_n = 0;
		cyc(3);
		for (int b = 0; b < n; b++) begin
			repeat (16) #400 spi_sck = ~spi_sck;
			@(negedge clock);
			tx_byte_strobe = 1;
			cyc(1);
			tx_byte_strobe = 0;
		end
		spi_select_n = 1;
		cyc(6);
	endtask : load
	task sw(input logic [2:0] d);
		status_write_data = d;
		status_write = 1;
		cyc(1);
		status_write = 0;
		cyc(1);
	endtask : sw
	task wait_flag(input int lim, input logic which);
		for (int i = 0; i < lim; i++) begin
			if ((which ? retry_exhausted_flag : transmit_done_flag) === 1'b1)
				break;
			cyc(1);
		end
	endtask : wait_flag
	task pkt(input logic m, input logic c, input logic [2:0] p, input logic k);
		rx_addr_match = m;
		rx_crc_ok = c;
		rx_pipe = p;
		rx_skip_ack = k;
		rx_packet_valid = 1;
		cyc(1);
		rx_packet_valid = 0;
		cyc(25);
	endtask : pkt
	task t_tx_ack;
		load(5);
		s = starts;
		radio_activate = 1;
		cyc(8);
		chk_val(starts - s, 1, "start");
		chk_val(last_len, 5, "length");
		chk_bit(radio_power_up, 1, "power");
		chk_bit(radio_rate_2m, 1, "rate");
		cyc(20);
		chk_bit(radio_rx_on, 1, "listen");
		wait_flag(60, 0);
		chk_bit(transmit_done_flag, 1, "done");
		chk_bit(irq_n, 0, "irq");
		chk_val(retry_count, 0, "retries");
		cyc(100);
		load(4);
		chk_val(starts - s, 2, "queued start");
		chk_val(last_len, 4, "second length");
		cyc(100);
		radio_activate = 0;
		cyc(4);
		load(3);
		cyc(20);
		chk_val(starts - s, 2, "idle after low");
		chk_bit(radio_power_up, 0, "standby power");
		sw(3'b000);
		chk_bit(transmit_done_flag, 1, "zero write");
		sw(3'b010);
		chk_bit(transmit_done_flag, 0, "cleared");
		chk_bit(irq_n, 1, "irq off");
	endtask : t_tx_ack
	task t_exhaust;
		ack_enable = 0;
		s = starts;
		radio_activate = 1;
		wait_flag(9000, 1);
		chk_val(starts - s, 3, "sends");
		chk_bit(retry_exhausted_flag, 1, "exhaust");
		chk_val(retry_count, 2, "retry count");
		chk_val(lost_packet_count, 1, "lost");
		chk_bit(irq_n, 0, "irq");
		cyc(100);
		radio_activate = 0;
		cyc(5);
		radio_activate = 1;
		cyc(110);
		chk_val(starts - s, 3, "blocked");
		radio_activate = 0;
		retry_limit = 4'h0;
		sw(3'b001);
		chk_bit(retry_exhausted_flag, 0, "cleared");
		s = starts;
		radio_activate = 1;
		radio_packet_active = 1;
		cyc(2600);
		chk_bit(radio_rx_on, 1, "held by packet");
		radio_packet_active = 0;
		wait_flag(3000, 1);
		chk_val(starts - s, 1, "no retransmit");
		chk_val(lost_packet_count, 2, "lost");
		cyc(100);
		radio_activate = 0;
		cyc(5);
		sw(3'b001);
		ack_enable = 1;
		slow = 1;
		radio_activate = 1;
		wait_flag(400, 0);
		chk_val(last_len, 3, "payload kept");
		chk_bit(transmit_done_flag, 1, "slow ack");
		cyc(100);
		radio_activate = 0;
		slow = 0;
		sw(3'b010);
	endtask : t_exhaust
	task t_skip;
		tx_skip_ack = 1;
		air_rate_2m = 0;
		load(2);
		radio_activate = 1;
		cyc(30);
		chk_bit(transmit_done_flag, 1, "skip done");
		chk_bit(radio_rx_on, 0, "skip no listen");
		chk_bit(radio_rate_2m, 0, "rate 1m");
		cyc(80);
		radio_activate = 0;
		tx_skip_ack = 0;
		air_rate_2m = 1;
		sw(3'b010);
	endtask : t_skip
	task t_rx;
		ack_enable = 0;
		load(6);
		primary_receive_select = 1;
		pipe_enable_mask = 6'h0f;
		auto_ack_enable_mask = 6'h08;
		radio_activate = 1;
		cyc(1290);
		chk_bit(radio_rx_on, 0, "settling");
		cyc(20);
		chk_bit(radio_rx_on, 1, "listening");
		s = starts;
		pkt(1, 0, 3'h3, 0);
		pkt(0, 1, 3'h3, 0);
		chk_bit(receive_ready_flag, 0, "rejected");
		chk_val(rx_fifo_count, 0, "rejected");
		pkt(1, 1, 3'h3, 0);
		chk_bit(receive_ready_flag, 1, "accepted");
		chk_val(receive_pipe_number, 3, "pipe");
		chk_bit(irq_n, 0, "irq");
		chk_val(starts - s, 1, "ack sent");
		chk_bit(last_awp, 1, "attached");
		chk_val(last_len, 6, "ack length");
		pkt(1, 1, 3'h3, 1);
		chk_val(starts - s, 1, "skip no ack");
		chk_val(rx_fifo_count, 2, "stored");
		radio_activate = 0;
		cyc(5);
		chk_bit(radio_rx_on, 0, "standby");
		clk_en = 0;
		rx_fifo_read = 1;
		cyc(1);
		rx_fifo_read = 0;
		clk_en = 1;
		chk_val(rx_fifo_count, 2, "frozen");
		repeat (2) begin
			rx_fifo_read = 1;
			cyc(1);
			rx_fifo_read = 0;
			cyc(1);
		end
		chk_val(rx_fifo_count, 0, "drained");
		sw(3'b100);
		chk_bit(irq_n, 1, "irq off");
	endtask : t_rx
	initial begin
		cyc(2);
		rst = 0;
		chk_bit(irq_n, 1, "reset irq");
		chk_val(lost_packet_count, 0, "reset lost");
		cyc(2);
		t_tx_ack();
		t_exhaust();
		t_skip();
		t_rx();
		results();
	end
endmodule : tb
